// ---- tpd_pkg.sv ----
// ****************************************
// Constants of the state capture front end
// ****************************************
package tpd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_SINGLE = 8'h04;
    localparam logic [7:0] OFF_SLAVE  = 8'h08;
    localparam logic [7:0] OFF_MASTER = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_DATA   = 8'h14;
    // Field positions
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_DMX_BIT = 1;
    localparam int ST_NE_BIT    = 0;
    localparam int ST_WM_BIT    = 1;
    localparam int ST_OVF_BIT   = 2;
    localparam int ST_CNT_LSB   = 8;
    localparam int DATA_VLD_BIT = 16;
    // Reset values
    localparam logic [1:0]  CTRL_RST = 2'h0;
    localparam logic [14:0] ARR_RST  = 15'h0000;
    // Sizes
    localparam int NUM_CLK    = 5;
    localparam int POD_W      = 16;
    localparam int BYTE_W     = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int CODE_W     = 3;
    // Per clock input selection codes
    localparam logic [2:0] CK_OFF  = 3'h0;
    localparam logic [2:0] CK_FALL = 3'h1;
    localparam logic [2:0] CK_RISE = 3'h2;
    localparam logic [2:0] CK_BOTH = 3'h3;
    localparam logic [2:0] CK_HIGH = 3'h4;
    localparam logic [2:0] CK_LOW  = 3'h5;
    // One stored state record
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } tpd_rec_t;
    // Demultiplex phase
    typedef enum logic {PH_SLAVE, PH_MASTER} tpd_phase_t;
endpackage

// ---- tpd_capture.sv ----
`timescale 1ns/1ns

// ****************************************
// Record FIFO
// ****************************************
module tpd_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 32
) (
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire logic [W-1:0]           in_data,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic [W-1:0]                out_data,
    output logic [$clog2(DEPTH):0]      count
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_reg [DEPTH];     // Storage
    logic [AW:0]  wp_reg;              // Write pointer with wrap bit
    logic [AW:0]  rp_reg;              // Read pointer with wrap bit
    logic         push;
    logic         pop;

    assign count     = wp_reg - rp_reg;
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem_reg[rp_reg[AW-1:0]];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            if (push) wp_reg <= wp_reg + 1'b1;
            if (pop)  rp_reg <= rp_reg + 1'b1;
        end
    end

    // Data store, no reset needed
    always_ff @(posedge clk_sys) begin
        if (push) mem_reg[wp_reg[AW-1:0]] <= in_data;
    end
endmodule

// ****************************************
// Capture front end with APB registers
// ****************************************
module tpd_capture #(
    parameter int NCLK  = tpd_pkg::NUM_CLK,
    parameter int DEPTH = tpd_pkg::FIFO_DEPTH
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NCLK-1:0]   link_clk,
    input  wire logic [15:0]       pod_data
);
    import tpd_pkg::*;
    localparam int ARR_W = NCLK * CODE_W;
    localparam int CW    = $clog2(DEPTH) + 1;

    // ****************************************
    // Storage
    // ****************************************
    logic [1:0]       ctrl_reg;        // Enable and demux mode
    logic [ARR_W-1:0] single_reg;      // Single-phase arrangement
    logic [ARR_W-1:0] slave_reg;       // First-phase arrangement
    logic [ARR_W-1:0] master_reg;      // Second-phase arrangement
    logic             ovf_reg;         // Record lost on full FIFO
    logic [7:0]       slave_byte_reg;  // First byte of a state
    tpd_phase_t       phase_reg;       // Demux phase
    logic [NCLK-1:0]  ck_s1_reg;       // Clock sync stage one
    logic [NCLK-1:0]  ck_s2_reg;       // Clock sync stage two
    logic [NCLK-1:0]  ck_prv_reg;      // Previous clock level
    logic [15:0]      pod_s1_reg;      // Pod sync stage one
    logic [15:0]      pod_s2_reg;      // Pod sync stage two
    logic [31:0]      prdata_reg;
    logic             pready_reg;
    logic             pslverr_reg;

    logic             en;
    logic             dmx;
    logic             m_single;
    logic             m_slave;
    logic             m_master;
    logic             push_valid;
    tpd_rec_t         push_data;
    logic             fifo_ready;
    logic             fifo_valid;
    tpd_rec_t         fifo_data;
    logic [CW-1:0]    fifo_count;
    logic             fifo_pop;
    logic             setup;
    logic             acc;
    logic             wr;
    logic             rd;
    logic             mapped;
    logic [31:0]      rd_mux;

    assign en  = ctrl_reg[CTRL_EN_BIT];
    assign dmx = ctrl_reg[CTRL_DMX_BIT];

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Two stages on every clock and data line, then edge history
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ck_s1_reg  <= '0;
            ck_s2_reg  <= '0;
            ck_prv_reg <= '0;
            pod_s1_reg <= '0;
            pod_s2_reg <= '0;
        end else begin
            ck_s1_reg  <= link_clk;
            ck_s2_reg  <= ck_s1_reg;
            ck_prv_reg <= ck_s2_reg;
            pod_s1_reg <= pod_data;
            pod_s2_reg <= pod_s1_reg;
        end
    end

    // ****************************************
    // Clocking arrangement match
    // ****************************************
    // Edges ORed, levels ORed, the two ANDed; no edge, no match
    function automatic logic arr_match(
        input logic [ARR_W-1:0] cfg,
        input logic [NCLK-1:0]  cur,
        input logic [NCLK-1:0]  prv
    );
        logic       e_any;
        logic       l_any;
        logic       l_used;
        logic [2:0] c;
        e_any  = 1'b0;
        l_any  = 1'b0;
        l_used = 1'b0;
        for (int i = 0; i < NCLK; i++) begin
            c = cfg[i*CODE_W +: CODE_W];
            case (c)
                CK_FALL: e_any = e_any | (prv[i] & ~cur[i]);
                CK_RISE: e_any = e_any | (~prv[i] & cur[i]);
                CK_BOTH: e_any = e_any | (prv[i] ^ cur[i]);
                CK_HIGH: begin
                    l_used = 1'b1;
                    l_any  = l_any | cur[i];
                end
                CK_LOW: begin
                    l_used = 1'b1;
                    l_any  = l_any | ~cur[i];
                end
                default: ;
            endcase
        end
        return e_any & (l_any | ~l_used);
    endfunction

    // Matches only occur on an edge of an external clock
    assign m_single = arr_match(single_reg, ck_s2_reg, ck_prv_reg);
    assign m_slave  = arr_match(slave_reg, ck_s2_reg, ck_prv_reg);
    assign m_master = arr_match(master_reg, ck_s2_reg, ck_prv_reg);

    // ****************************************
    // Record building
    // ****************************************
    // Pod value aligned with the clock edge that qualified it
    always_comb begin
        push_valid = 1'b0;
        push_data  = '0;
        if (en && !dmx && m_single) begin
            // All sixteen lines together
            push_valid = 1'b1;
            push_data  = pod_s2_reg;
        end else if (en && dmx && phase_reg == PH_MASTER &&
                     m_master) begin
            // Master byte high, slave byte low
            push_valid   = 1'b1;
            push_data.hi = pod_s2_reg[BYTE_W-1:0];
            push_data.lo = slave_byte_reg;
        end
    end

    // ****************************************
    // Demux phase sequencer
    // ****************************************
    // A slave event only arms; the master event must be a later one
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg      <= PH_SLAVE;
            slave_byte_reg <= '0;
        end else if (!(en && dmx)) begin
            phase_reg <= PH_SLAVE;
        end else begin
            case (phase_reg)
                PH_SLAVE: begin
                    // Lower lines only; upper lines never read
                    if (m_slave) begin
                        slave_byte_reg <= pod_s2_reg[BYTE_W-1:0];
                        phase_reg      <= PH_MASTER;
                    end
                end
                PH_MASTER: begin
                    // Slave matches here are ignored
                    if (m_master) begin
                        phase_reg <= PH_SLAVE;
                    end
                end
                default: phase_reg <= PH_SLAVE;
            endcase
        end
    end

    // ****************************************
    // Record FIFO
    // ****************************************
    tpd_fifo #(
        .W     (POD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_valid  (push_valid),
        .in_ready  (fifo_ready),
        .in_data   (push_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data),
        .count     (fifo_count)
    );

    // ****************************************
    // APB slave
    // ****************************************
    assign setup  = psel & ~penable;
    assign acc    = psel & penable & pready_reg;
    assign wr     = acc & pwrite;
    assign rd     = acc & ~pwrite;
    assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_SINGLE) ||
                    (paddr == OFF_SLAVE) || (paddr == OFF_MASTER) ||
                    (paddr == OFF_STATUS) || (paddr == OFF_DATA);
    // Pop only a record that the read actually returned
    assign fifo_pop = rd && (paddr == OFF_DATA) &&
                      prdata_reg[DATA_VLD_BIT];

    // Read data selection
    always_comb begin
        rd_mux = '0;
        case (paddr)
            OFF_CTRL:   rd_mux[1:0] = ctrl_reg;
            OFF_SINGLE: rd_mux[ARR_W-1:0] = single_reg;
            OFF_SLAVE:  rd_mux[ARR_W-1:0] = slave_reg;
            OFF_MASTER: rd_mux[ARR_W-1:0] = master_reg;
            OFF_STATUS: begin
                rd_mux[ST_NE_BIT]  = fifo_valid;
                rd_mux[ST_WM_BIT]  = (phase_reg == PH_MASTER);
                rd_mux[ST_OVF_BIT] = ovf_reg;
                rd_mux[ST_CNT_LSB +: CW] = fifo_count;
            end
            OFF_DATA: begin
                rd_mux[POD_W-1:0]    = fifo_data;
                rd_mux[DATA_VLD_BIT] = fifo_valid;
            end
            default: rd_mux = '0;
        endcase
    end

    // Answer one cycle after setup; access phase is one cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~mapped;
            if (setup && !pwrite) prdata_reg <= rd_mux;
        end
    end

    // Configuration writes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg   <= CTRL_RST;
            single_reg <= ARR_W'(ARR_RST);
            slave_reg  <= ARR_W'(ARR_RST);
            master_reg <= ARR_W'(ARR_RST);
        end else if (wr) begin
            case (paddr)
                OFF_CTRL:   ctrl_reg   <= pwdata[1:0];
                OFF_SINGLE: single_reg <= pwdata[ARR_W-1:0];
                OFF_SLAVE:  slave_reg  <= pwdata[ARR_W-1:0];
                OFF_MASTER: master_reg <= pwdata[ARR_W-1:0];
                default: ;
            endcase
        end
    end

    // Overflow: set on a refused record, write one clears, set wins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= (push_valid & ~fifo_ready) |
                       (ovf_reg & ~(wr && paddr == OFF_STATUS &&
                                    pwdata[ST_OVF_BIT]));
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    single_sample_a: assert property (
        en && !dmx && m_single |-> push_valid && push_data == pod_s2_reg)
        else $error("single-phase match did not store pod");
    slave_latch_a: assert property (
        en && dmx && phase_reg == PH_SLAVE && m_slave |=>
        phase_reg == PH_MASTER &&
        slave_byte_reg == $past(pod_s2_reg[7:0]))
        else $error("slave byte not latched");
    master_pair_a: assert property (
        en && dmx && phase_reg == PH_MASTER && m_master |->
        push_valid && push_data.hi == pod_s2_reg[7:0] &&
        push_data.lo == slave_byte_reg)
        else $error("master record wrong");
    phase_order_a: assert property (
        en && dmx && push_valid |-> phase_reg == PH_MASTER ##1
        phase_reg == PH_SLAVE || !(en && dmx))
        else $error("record out of phase order");
    two_events_a: assert property (
        en && dmx && phase_reg == PH_SLAVE |-> !push_valid)
        else $error("record stored on slave event");
    edge_only_a: assert property (
        m_single || m_slave || m_master |-> ck_s2_reg != ck_prv_reg)
        else $error("match without clock edge");
    overflow_flag_a: assert property (
        push_valid && !fifo_ready |=> ovf_reg)
        else $error("lost record not flagged");
    apb_answer_a: assert property (
        psel && !penable |=> pready_reg ##1 !pready_reg)
        else $error("APB answer timing wrong");

    single_push_c: cover property (en && !dmx && push_valid);
    demux_push_c:  cover property (en && dmx && push_valid);
    overflow_c:    cover property (push_valid && !fifo_ready);
    data_pop_c:    cover property (fifo_pop);
endmodule

// ---- tpd_target.sv ----
`timescale 1ns/1ns

// ****************************************
// Observed target bus with shared lines
// ****************************************
module tpd_target (
    output logic [4:0]  link_clk,
    output logic [15:0] pod_data
);
    // Strobes rest low between bus cycles
    initial begin
        link_clk = 5'h00;
        pod_data = 16'h0000;
    end

    // One bus cycle: address phase on strobe 0, data phase on strobe 1
    task automatic frame(input logic [7:0] adr, input logic [7:0] dat,
                         input logic [7:0] hi);
        // Changes land just after a sampling edge, never racing it
        pod_data <= {hi, adr};
        #400 link_clk[0] <= 1'b1;
        #400 link_clk[0] <= 1'b0;
        #400 pod_data <= {hi, dat};
        #400 link_clk[1] <= 1'b1;
        #400 link_clk[1] <= 1'b0;
        // Hold time over: lines drift instead of keeping the last value
        #400 pod_data <= ~pod_data;
        // Idle gap, so the drifted value is really seen before the next cycle
        #400;
    endtask

    // Static levels on the remaining clock inputs
    task automatic set_lvl(input logic [2:0] l);
        link_clk[4:2] <= l;
    endtask
endmodule

// ---- tb_two_phase_demux_state_capture.sv ----
`timescale 1ns/1ns

module tb_two_phase_demux_state_capture;
    import tpd_pkg::*;
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; \
    $display("[ERR] %s expected %h seen %h", n, e, s); end end

    // ****************************************
    // Signals and bench state
    // ****************************************
    logic        clk_sys;
    logic        reset_n;
    logic        psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr;
    logic [4:0]  link_clk;
    logic [15:0] pod_data;
    int          n_fail, cmp_count;
    logic [31:0] seed;                  // Xorshift state
    logic [15:0] q[$];                  // Expected records
    logic [14:0] arr[3];                // Single, slave, master
    logic [1:0]  ctrl;
    logic [2:0]  lvl;
    logic        ph, ovf;               // Waiting for master, overflow
    logic [7:0]  pend;                  // Pending slave byte

    tpd_capture tpd_capture_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_clk(link_clk), .pod_data(pod_data));
    tpd_target tpd_target_inst (.link_clk(link_clk), .pod_data(pod_data));

    // Free running system clock
    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Edge terms ORed, level terms ORed, both ANDed
    function automatic logic hit(input logic [14:0] a,
                                 input logic [4:0] cur, input logic [4:0] prv);
        logic e, l, any;
        logic [2:0] c;
        e = 1'b0;
        l = 1'b0;
        any = 1'b0;
        for (int i = 0; i < 5; i++) begin
            c = a[3*i +: 3];
            if ((c == CK_FALL || c == CK_BOTH) && prv[i] && !cur[i]) e = 1'b1;
            if ((c == CK_RISE || c == CK_BOTH) && !prv[i] && cur[i]) e = 1'b1;
            if (c == CK_HIGH) begin
                any = 1'b1;
                l = l | cur[i];
            end
            if (c == CK_LOW) begin
                any = 1'b1;
                l = l | !cur[i];
            end
        end
        return e && (l || !any);
    endfunction

    // Queue a record, dropping it when the buffer is full
    task automatic push(input logic [15:0] r);
        if (q.size() < FIFO_DEPTH) q.push_back(r);
        else ovf = 1'b1;
    endtask

    // Expected records of one bus cycle, event by event
    task automatic predict(input logic [7:0] ad, input logic [7:0] da,
                           input logic [7:0] hi);
        logic [4:0] st[5];
        logic [7:0] v;
        st = '{{lvl, 2'b00}, {lvl, 2'b01}, {lvl, 2'b00}, {lvl, 2'b10},
               {lvl, 2'b00}};
        for (int k = 1; k < 5; k++) begin
            v = (k < 3) ? ad : da;
            if (!ctrl[0]) begin
                // Disabled: nothing stored
            end else if (!ctrl[1]) begin
                if (hit(arr[0], st[k], st[k-1])) push({hi, v});
            end else if (!ph) begin
                if (hit(arr[1], st[k], st[k-1])) begin
                    pend = v;
                    ph = 1'b1;
                end
            end else if (hit(arr[2], st[k], st[k-1])) begin
                push({v, pend});
                ph = 1'b0;
            end
        end
    endtask

    // APB transfer, entered and left just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        // Setup phase
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        // Access phase, held until pready is seen high at a rising edge
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk_sys);
            n++;
        end
        // No answer: count it and end the run
        if (n == 16) begin
            n_fail++;
            stop_test();
        end
        // Answer taken at the same edge, then the request is released
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ****************************************
    // One configuration, nf bus cycles
    // ****************************************
    task automatic run_cfg(input logic [1:0] c, input logic [14:0] s0,
                           input logic [14:0] s1, input logic [14:0] s2,
                           input logic [2:0] l, input int nf);
        logic [31:0] r;
        logic e;
        logic [7:0] ad, da, hi;
        logic [31:0] x;                 // Expected word
        apb(1'b1, OFF_CTRL, 32'h0, r, e);
        ph = 1'b0;
        lvl = l;
        tpd_target_inst.set_lvl(l);
        arr = '{s0, s1, s2};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFF_SINGLE + 8'(4 * i), {17'h0, arr[i]}, r, e);
            apb(1'b0, OFF_SINGLE + 8'(4 * i), 32'h0, r, e);
            `CHK("arrangement", {17'h0, arr[i]}, r)
        end
        ctrl = c;
        apb(1'b1, OFF_CTRL, {30'h0, c}, r, e);
        repeat (nf) begin
            ad = 8'(rnd());
            da = 8'(rnd());
            hi = 8'(rnd());
            tpd_target_inst.frame(ad, da, hi);
            predict(ad, da, hi);
        end
        apb(1'b0, OFF_STATUS, 32'h0, r, e);
        x = {18'h0, 6'(q.size()), 5'h0, ovf, ph, q.size() != 0};
        `CHK("status", x, r)
        // Clear a latched overflow before draining
        if (ovf) begin
            apb(1'b1, OFF_STATUS, 32'h4, r, e);
            ovf = 1'b0;
        end
        while (q.size() > 0) begin
            apb(1'b0, OFF_DATA, 32'h0, r, e);
            // Pop once, so a mismatch report shows the same record
            x = {15'h0, 1'b1, q.pop_front()};
            `CHK("record", x, r)
        end
        apb(1'b0, OFF_DATA, 32'h0, r, e);
        `CHK("empty", 32'h0, r & 32'h10000)
        apb(1'b0, OFF_STATUS, 32'h0, r, e);
        `CHK("status after drain", {30'h0, ph, 1'b0}, r)
        $display("test done ctrl %h arr %h %h %h", c, s0, s1, s2);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] r;
        logic e;
        logic [14:0] ra[3];
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        reset_n = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        seed = 32'h42;
        ph = 1'b0;
        ovf = 1'b0;
        ctrl = 2'h0;
        lvl = 3'h0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        // Reset values and an unmapped place
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, r, e);
            `CHK("reset value", 32'h0, r)
        end
        apb(1'b1, 8'h1c, 32'hffffffff, r, e);
        `CHK("unmapped write error", 1'b1, e)
        apb(1'b0, 8'h1c, 32'h0, r, e);
        `CHK("unmapped read", 33'h100000000, {e, r})
        $display("test done reset and map");
        // Corner configurations
        run_cfg(2'h1, 15'h0011, 15'h0, 15'h0, 3'h0, 2);
        run_cfg(2'h3, 15'h0, 15'h0001, 15'h0010, 3'h0, 3);
        run_cfg(2'h3, 15'h0, 15'h0012, 15'h0012, 3'h0, 2);
        run_cfg(2'h3, 15'h0, 15'h0003, 15'h0010, 3'h0, 2);
        run_cfg(2'h2, 15'h0, 15'h0003, 15'h0010, 3'h0, 1);
        run_cfg(2'h1, 15'h001b, 15'h0, 15'h0, 3'h0, 9);
        run_cfg(2'h1, 15'h0110, 15'h0, 15'h0, 3'h1, 1);
        run_cfg(2'h1, 15'h0150, 15'h0, 15'h0, 3'h1, 1);
        // Random configurations covering every selection code
        repeat (14) begin
            for (int j = 0; j < 3; j++)
                for (int i = 0; i < 5; i++)
                    ra[j][3*i +: 3] = 3'(rnd() % 6);
            run_cfg(2'(rnd()), ra[0], ra[1], ra[2], 3'(rnd()), 3);
        end
        stop_test();
    end
endmodule
